// File: hw/rxc_ctrl_regs.sv
`timescale 1ns/1ps
`include "rxc_consts.svh"
module rxc_ctrl_regs
  import rxc_pkg::*;
#(
  parameter logic [7:0] REV_VALUE = 8'h5A // Arbitrary revision code
) (
  input  wire logic        mclk,                  // 10 MHz clock
  input  wire logic        rst_n,                 // Async reset
  input  wire logic        spi_sclk,              // Serial clock pin
  input  wire logic        spi_cs_n,              // Chip select pin
  input  wire logic        spi_sdi,               // Serial data in
  output logic             spi_sdo,               // Serial data out
  output logic             spi_sdo_oe,            // Data out enable
  input  wire logic [7:0]  rx_setup,              // Receiver seq setup
  input  wire logic [7:0]  freq_setup,            // Frequency seq setup
  input  wire logic        rx_sleep,              // Receiver asleep
  input  wire logic        freq_sleep,            // Multiplier asleep
  input  wire logic [63:0] rx_slots,              // Receiver slot bytes
  input  wire logic [23:0] freq_low_slots,        // Freq slots 1..6
  input  wire logic [23:0] ext_mode_cfg,          // Modes 1..15 config
  input  wire logic [7:0]  freq_mode_cfg,         // Freq mode controls
  input  wire logic        conv_eoc,              // Converter done pin
  input  wire logic [7:0]  conv_result,           // Converter word
  output logic [3:0]       rx_channel_on,         // Ch1 in bit 3
  output logic [2:0]       rx_splitter_on,        // First, 1-2, 3-4
  output logic [11:0]      rx_channel_gain,       // Ch1 gain on top
  output logic             rx_low_noise_amp_on,   // Front amplifiers
  output logic             rx_mixer_on,           // Mixers
  output logic             rx_if_amplifier_on,    // IF amplifiers
  output logic [7:0]       mult_control,          // Filter and bands
  output logic [3:0]       receiver_active_mode,  // Applied rx mode
  output logic [3:0]       freq_active_mode,      // Applied freq mode
  output logic             converter_clock_rate_select, // Clock rate
  output logic             converter_enable,      // Comparator on
  output logic             converter_osc_on,      // Oscillator on
  output logic             conversion_start_pulse // Start level
);
  rxc_main_s    cur, nxt;
  rxc_regbus_if u_bus ();
  logic [3:0]   rx_count, freq_count, rx_mode, freq_mode;
  logic         rx_on, freq_on, rx_load, freq_load;
  logic [7:0]   rd_data, cfg_en, cfg_g12, cfg_g34;

  // Serial port front end
  rxc_spi_slave u_spi (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .bus        (u_bus)
  );

  // enable and length come from setup
  assign rx_on   = rx_setup[`RXC_B_SEQ_ON];
  assign freq_on = freq_setup[`RXC_B_SEQ_ON];

  // Receiver sequencer, frozen while multiplier sleeps
  rxc_sequencer u_rx_seq (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .enable  (rx_on),
    .length  (rx_setup[3:0]),
    .restart (cur.pulse[`RXC_B_RRESTART]),
    .step    (cur.pulse[`RXC_B_RSTEP]),
    .freeze  (rx_setup[`RXC_B_FREEZE] & freq_sleep),
    .slots   (rx_slots),
    .count   (rx_count),
    .mode    (rx_mode)
  );

  // Frequency sequencer; upper slot bytes live here
  rxc_sequencer u_freq_seq (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .enable  (freq_on),
    .length  (freq_setup[3:0]),
    .restart (cur.pulse[`RXC_B_FRESTART]),
    .step    (cur.pulse[`RXC_B_FSTEP]),
    .freeze  (freq_setup[`RXC_B_FREEZE] & rx_sleep),
    .slots   ({cur.fslot, freq_low_slots}),
    .count   (freq_count),
    .mode    (freq_mode)
  );

  // with sequencer on and no bypass, controls reload only after a seq event
  assign rx_load   = !rx_on || rx_setup[`RXC_B_BYPASS] || cur.evt[0];
  assign freq_load = !freq_on || freq_setup[`RXC_B_BYPASS] || cur.evt[1];

  // mode 0 held here, other modes supplied from outside
  always_comb begin
    cfg_en  = {1'b0, cur.m0en};
    cfg_g12 = cur.m0g12;
    cfg_g34 = cur.m0g34;
    if (rx_mode != 4'h0) begin
      cfg_en  = ext_mode_cfg[23:16];
      cfg_g12 = ext_mode_cfg[15:8];
      cfg_g34 = ext_mode_cfg[7:0];
    end
  end

  // Register writes and control application
  always_comb begin
    nxt       = cur;
    nxt.pulse = 4'h0;
    // Step and restart pulses reach the counters one cycle on
    nxt.evt   = {|cur.pulse[3:2], |cur.pulse[1:0]};
    if (u_bus.wr) begin
      case (u_bus.addr)
        `RXC_A_FSLOT78:   nxt.fslot[0] = u_bus.wdata;
        `RXC_A_FSLOT910:  nxt.fslot[1] = u_bus.wdata;
        `RXC_A_FSLOT1112: nxt.fslot[2] = u_bus.wdata;
        `RXC_A_FSLOT1314: nxt.fslot[3] = u_bus.wdata;
        `RXC_A_FSLOT1516: nxt.fslot[4] = u_bus.wdata;
        // writing a one fires the strobe
        `RXC_A_SEQCTL: begin
          nxt.seqctl = u_bus.wdata[3:0];
          nxt.pulse  = u_bus.wdata[3:0];
        end
        `RXC_A_DRXEN:  nxt.drxen = u_bus.wdata;
        `RXC_A_DG12:   nxt.dg12  = u_bus.wdata & `RXC_M_GAIN;
        `RXC_A_DG34:   nxt.dg34  = u_bus.wdata & `RXC_M_GAIN;
        `RXC_A_DSPL:   nxt.dspl  = u_bus.wdata[2:0];
        `RXC_A_DMULT:  nxt.dmult = u_bus.wdata;
        `RXC_A_TCCTL:  nxt.tcctl = u_bus.wdata & `RXC_M_TCCTL;
        `RXC_A_M0EN:   nxt.m0en  = u_bus.wdata[6:0];
        `RXC_A_M0G12:  nxt.m0g12 = u_bus.wdata & `RXC_M_GAIN;
        `RXC_A_M0G34:  nxt.m0g34 = u_bus.wdata & `RXC_M_GAIN;
        default: ;
      endcase
    end
    // done flag synchronised; result caught as it rises
    nxt.eoc_s1 = conv_eoc;
    nxt.eoc_s2 = cur.eoc_s1;
    nxt.eoc    = cur.eoc_s2;
    if (cur.eoc_s2 && !cur.eoc) nxt.tcres = conv_result;
    // chain enables always from direct bits
    nxt.chain = cur.drxen[7:5];
    // receiver controls from mode or direct fields
    if (rx_load) begin
      if (!rx_on) begin
        nxt.ch_on = cur.drxen[3:0];
        nxt.spl   = cur.dspl;
        nxt.gain  = {cur.dg12[6:4], cur.dg12[2:0],
                     cur.dg34[6:4], cur.dg34[2:0]};
      end else begin
        nxt.ch_on = cfg_en[3:0];
        nxt.spl   = cfg_en[6:4];
        // gain fields packed channel 1 first
        nxt.gain  = {cfg_g12[6:4], cfg_g12[2:0],
                     cfg_g34[6:4], cfg_g34[2:0]};
      end
    end
    if (freq_load) nxt.mult = freq_on ? freq_mode_cfg : cur.dmult;
  end

  // Single state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cur <= `RXC_RST_VAL;
    else        cur <= nxt;
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    case (u_bus.addr)
      `RXC_A_FSLOT78:   rd_data = cur.fslot[0];
      `RXC_A_FSLOT910:  rd_data = cur.fslot[1];
      `RXC_A_FSLOT1112: rd_data = cur.fslot[2];
      `RXC_A_FSLOT1314: rd_data = cur.fslot[3];
      `RXC_A_FSLOT1516: rd_data = cur.fslot[4];
      `RXC_A_SEQCTL:    rd_data = {4'h0, cur.seqctl};
      `RXC_A_DRXEN:     rd_data = cur.drxen;
      `RXC_A_DG12:      rd_data = cur.dg12;
      `RXC_A_DG34:      rd_data = cur.dg34;
      `RXC_A_DSPL:      rd_data = {5'h00, cur.dspl};
      `RXC_A_DMULT:     rd_data = cur.dmult;
      `RXC_A_TCCTL:     rd_data = {cur.tcctl[7:1], cur.eoc};
      `RXC_A_TCRES:     rd_data = cur.tcres;
      `RXC_A_RXST:      rd_data = {rx_count, rx_mode};
      `RXC_A_FST:       rd_data = {freq_count, freq_mode};
      `RXC_A_REV:       rd_data = REV_VALUE;
      `RXC_A_M0EN:      rd_data = {1'b0, cur.m0en};
      `RXC_A_M0G12:     rd_data = cur.m0g12;
      `RXC_A_M0G34:     rd_data = cur.m0g34;
      default:          rd_data = 8'h00;
    endcase
  end

  assign u_bus.rdata = rd_data;

  // Outputs straight from flip-flops
  assign rx_channel_on               = cur.ch_on;
  assign rx_splitter_on              = cur.spl;
  assign rx_channel_gain             = cur.gain;
  assign rx_low_noise_amp_on         = cur.chain[2];
  assign rx_mixer_on                 = cur.chain[1];
  assign rx_if_amplifier_on          = cur.chain[0];
  assign mult_control                = cur.mult;
  assign receiver_active_mode        = rx_mode;
  assign freq_active_mode            = freq_mode;
  assign converter_clock_rate_select = cur.tcctl[7];
  assign converter_enable            = cur.tcctl[6];
  assign converter_osc_on            = cur.tcctl[5];
  // start follows the host's write-one, write-zero pulse
  assign conversion_start_pulse      = cur.tcctl[4];

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_slot_store;
    u_bus.wr && u_bus.addr == `RXC_A_FSLOT1516
      |=> cur.fslot[4] == $past(u_bus.wdata);
  endproperty
  a_slot_store: assert property (p_slot_store)
    else $error("slot byte not stored");

  property p_frestart;
    u_bus.wr && u_bus.addr == `RXC_A_SEQCTL && u_bus.wdata[3]
      |-> ##2 freq_count == 4'h0;
  endproperty
  a_frestart: assert property (p_frestart)
    else $error("frequency restart missed");

  property p_rrestart;
    u_bus.wr && u_bus.addr == `RXC_A_SEQCTL && u_bus.wdata[1]
      |-> ##2 rx_count == 4'h0;
  endproperty
  a_rrestart: assert property (p_rrestart)
    else $error("receiver restart missed");

  property p_direct_rx;
    !rx_on |=> rx_channel_on == $past(cur.drxen[3:0])
               && rx_splitter_on == $past(cur.dspl);
  endproperty
  a_direct_rx: assert property (p_direct_rx)
    else $error("direct enables not applied");

  property p_chain;
    u_bus.wr && u_bus.addr == `RXC_A_DRXEN
      |-> ##2 rx_low_noise_amp_on == $past(u_bus.wdata[7], 2)
              && rx_if_amplifier_on == $past(u_bus.wdata[5], 2);
  endproperty
  a_chain: assert property (p_chain)
    else $error("chain enables wrong");

  property p_gain_rsvd;
    u_bus.addr == `RXC_A_DG12 |-> rd_data[7] == 1'b0 && !rd_data[3];
  endproperty
  a_gain_rsvd: assert property (p_gain_rsvd)
    else $error("reserved gain bit set");

  property p_direct_mult;
    !freq_on |=> mult_control == $past(cur.dmult);
  endproperty
  a_direct_mult: assert property (p_direct_mult)
    else $error("multiplier control wrong");

  property p_conv_ctl;
    u_bus.wr && u_bus.addr == `RXC_A_TCCTL
      |-> ##2 {converter_clock_rate_select, converter_enable,
               converter_osc_on} == $past(u_bus.wdata[7:5], 2);
  endproperty
  a_conv_ctl: assert property (p_conv_ctl)
    else $error("converter control wrong");

  property p_result;
    $rose(cur.eoc) |-> cur.tcres == $past(conv_result);
  endproperty
  a_result: assert property (p_result)
    else $error("result not captured");

  property p_rx_status;
    u_bus.addr == `RXC_A_RXST |-> rd_data == {rx_count, rx_mode};
  endproperty
  a_rx_status: assert property (p_rx_status)
    else $error("receiver status wrong");

  property p_f_status;
    u_bus.addr == `RXC_A_FST |-> rd_data[7:4] == freq_count;
  endproperty
  a_f_status: assert property (p_f_status)
    else $error("frequency status wrong");

  property p_mode0;
    rx_on && rx_setup[`RXC_B_BYPASS] && rx_mode == 4'h0
      |=> rx_channel_on == $past(cur.m0en[3:0])
          && rx_channel_gain[11:9] == $past(cur.m0g12[6:4]);
  endproperty
  a_mode0: assert property (p_mode0)
    else $error("mode 0 not applied");

  property p_latch;
    rx_on && !rx_setup[`RXC_B_BYPASS] && !cur.evt[0]
      |=> $stable(rx_channel_on);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched controls moved");

  c_read:  cover property (u_bus.rd);
  c_fstep: cover property (cur.pulse[`RXC_B_FSTEP] && freq_on);
  c_eoc:   cover property ($rose(cur.eoc));
  c_mode:  cover property (rx_on && rx_mode != 4'h0);
endmodule : rxc_ctrl_regs

// File: shared/rxc_consts.svh
`ifndef RXC_CONSTS_SVH
`define RXC_CONSTS_SVH
// Register offsets
`define RXC_A_FSLOT78   15'h0025
`define RXC_A_FSLOT910  15'h0026
`define RXC_A_FSLOT1112 15'h0027
`define RXC_A_FSLOT1314 15'h0028
`define RXC_A_FSLOT1516 15'h0029
`define RXC_A_SEQCTL    15'h002A
`define RXC_A_DRXEN     15'h002B
`define RXC_A_DG12      15'h002C
`define RXC_A_DG34      15'h002D
`define RXC_A_DSPL      15'h002E
`define RXC_A_DMULT     15'h002F
`define RXC_A_TCCTL     15'h0030
`define RXC_A_TCRES     15'h0031
`define RXC_A_RXST      15'h0032
`define RXC_A_FST       15'h0033
`define RXC_A_REV       15'h0034
`define RXC_A_M0EN      15'h0040
`define RXC_A_M0G12     15'h0041
`define RXC_A_M0G34     15'h0042
// Field positions
`define RXC_B_FRESTART  3
`define RXC_B_FSTEP     2
`define RXC_B_RRESTART  1
`define RXC_B_RSTEP     0
`define RXC_B_SEQ_ON    7
`define RXC_B_FREEZE    5
`define RXC_B_BYPASS    4
`define RXC_B_EOC       0
// Writable-bit masks
`define RXC_M_GAIN      8'h77
`define RXC_M_TCCTL     8'hFE
// Reset value of every held bit
`define RXC_RST_VAL     '0
// Serial frame: read flag, 15 address bits, 8 data bits
`define RXC_HDR_BITS    5'h0F
`define RXC_DATA_BITS   5'h07
`endif

// File: shared/rxc_pkg.sv
package rxc_pkg;
  typedef enum logic [1:0] {RXC_IDLE, RXC_HDR, RXC_DATA} rxc_spi_e;

  typedef struct packed {
    rxc_spi_e    st;
    logic [4:0]  cnt;
    logic [15:0] sh;
    logic [7:0]  osh;
    logic        sclk_s1, sclk_s2, sclk_s3;
    logic        cs_s1, cs_s2, sdi_s1, sdi_s2;
    logic        sdo, sdo_oe, rw, rd, wr;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } rxc_spi_s;

  parameter rxc_spi_s RXC_SPI_RST = '{st: RXC_IDLE, cs_s1: 1'b1,
                                      cs_s2: 1'b1, default: '0};

  typedef struct packed {
    logic [3:0] count;
    logic [3:0] mode;
  } rxc_seq_s;

  typedef struct packed {
    logic [4:0][7:0] fslot;
    logic [3:0]      seqctl;
    logic [3:0]      pulse;
    logic [1:0]      evt;
    logic [7:0]      drxen, dg12, dg34;
    logic [2:0]      dspl;
    logic [7:0]      dmult, tcctl, tcres;
    logic            eoc_s1, eoc_s2, eoc;
    logic [6:0]      m0en;
    logic [7:0]      m0g12, m0g34;
    logic [3:0]      ch_on;
    logic [2:0]      spl;
    logic [11:0]     gain;
    logic [2:0]      chain;
    logic [7:0]      mult;
  } rxc_main_s;

  // Mode nibble of state i+1: odd states sit in the upper nibble
  function automatic logic [3:0] rxc_slot_nib(input logic [63:0] s,
                                              input logic [3:0]  i);
    return s[{i[3:1], ~i[0], 2'b00} +: 4];
  endfunction : rxc_slot_nib
endpackage : rxc_pkg

// File: shared/rxc_regbus_if.sv
`timescale 1ns/1ps
interface rxc_regbus_if;
  logic        wr;
  logic        rd;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport master (output wr, rd, addr, wdata, input rdata);
  modport slave  (input wr, rd, addr, wdata, output rdata);
endinterface : rxc_regbus_if

// File: hw/rxc_spi_slave.sv
`timescale 1ns/1ps
`include "rxc_consts.svh"
module rxc_spi_slave
  import rxc_pkg::*;
(
  input  wire logic   mclk,       // System clock
  input  wire logic   rst_n,      // Async reset
  input  wire logic   spi_sclk,   // Serial clock pin
  input  wire logic   spi_cs_n,   // Chip select pin
  input  wire logic   spi_sdi,    // Serial data in
  output logic        spi_sdo,    // Serial data out
  output logic        spi_sdo_oe, // Data out enable
  rxc_regbus_if.master bus        // Register access
);
  rxc_spi_s cur, nxt;
  logic     rise, fall;

  // Edges seen only on second sync stage and later
  assign rise = cur.sclk_s2 & ~cur.sclk_s3;
  assign fall = ~cur.sclk_s2 & cur.sclk_s3;

  // Frame decoder; slow SCLK needed since pins are oversampled
  always_comb begin
    nxt         = cur;
    nxt.rd      = 1'b0;
    nxt.wr      = 1'b0;
    nxt.sclk_s1 = spi_sclk;
    nxt.sclk_s2 = cur.sclk_s1;
    nxt.sclk_s3 = cur.sclk_s2;
    nxt.cs_s1   = spi_cs_n;
    nxt.cs_s2   = cur.cs_s1;
    nxt.sdi_s1  = spi_sdi;
    nxt.sdi_s2  = cur.sdi_s1;
    case (cur.st)
      RXC_IDLE: begin
        nxt.cnt    = 5'h00;
        nxt.sdo_oe = 1'b0;
        if (!cur.cs_s2) nxt.st = RXC_HDR;
      end
      RXC_HDR: if (rise) begin
        nxt.sh  = {cur.sh[14:0], cur.sdi_s2};
        nxt.cnt = cur.cnt + 5'h01;
        if (cur.cnt == `RXC_HDR_BITS) begin
          nxt.st   = RXC_DATA;
          nxt.cnt  = 5'h00;
          nxt.rw   = cur.sh[14];
          nxt.rd   = cur.sh[14];
          nxt.addr = {cur.sh[13:0], cur.sdi_s2};
        end
      end
      RXC_DATA: begin
        if (cur.rd) nxt.osh = bus.rdata;
        if (fall && cur.rw) begin
          nxt.sdo    = cur.osh[7];
          nxt.osh    = {cur.osh[6:0], 1'b0};
          nxt.sdo_oe = 1'b1;
        end
        if (rise) begin
          nxt.sh = {cur.sh[14:0], cur.sdi_s2};
          if (cur.cnt != 5'h1F) nxt.cnt = cur.cnt + 5'h01;
          if (cur.cnt == `RXC_DATA_BITS && !cur.rw) begin
            nxt.wr    = 1'b1;
            nxt.wdata = {cur.sh[6:0], cur.sdi_s2};
          end
        end
      end
      default: nxt.st = RXC_IDLE;
    endcase
    if (cur.cs_s2) nxt.st = RXC_IDLE;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cur <= RXC_SPI_RST;
    else        cur <= nxt;
  end

  assign bus.wr     = cur.wr;
  assign bus.rd     = cur.rd;
  assign bus.addr   = cur.addr;
  assign bus.wdata  = cur.wdata;
  assign spi_sdo    = cur.sdo;
  assign spi_sdo_oe = cur.sdo_oe;
endmodule : rxc_spi_slave

// File: hw/rxc_sequencer.sv
`timescale 1ns/1ps
module rxc_sequencer
  import rxc_pkg::*;
(
  input  wire logic        mclk,    // System clock
  input  wire logic        rst_n,   // Async reset
  input  wire logic        enable,  // Sequencer on
  input  wire logic [3:0]  length,  // States in cycle
  input  wire logic        restart, // Back to first state
  input  wire logic        step,    // Next state
  input  wire logic        freeze,  // Hold while other sleeps
  input  wire logic [63:0] slots,   // Mode nibbles
  output logic [3:0]       count,   // Current state index
  output logic [3:0]       mode     // Mode of current state
);
  rxc_seq_s   cur, nxt;
  logic [3:0] last;

  // Length zero behaves as a single state
  assign last = (length == 4'h0) ? 4'h0 : length - 4'h1;

  always_comb begin
    nxt = cur;
    if (!enable) nxt.count = 4'h0;
    else if (restart) nxt.count = 4'h0;
    else if (step && !freeze)
      nxt.count = (cur.count >= last) ? 4'h0 : cur.count + 4'h1;
    nxt.mode = enable ? rxc_slot_nib(slots, nxt.count) : 4'h0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cur <= '0;
    else        cur <= nxt;
  end

  assign count = cur.count;
  assign mode  = cur.mode;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_wrap;
    enable && !restart && step && !freeze && cur.count == last
      |=> cur.count == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  c_wrap: cover property (enable && step && last != 4'h0 &&
                          cur.count == last);
endmodule : rxc_sequencer

// File: test/rxc_spi_host.sv
`timescale 1ns/1ps
module rxc_spi_host (
  input  wire logic mclk, // System clock
  output logic      sclk, // Serial clock, idle low
  output logic      cs_n, // Chip select
  output logic      sdi,  // Data to device
  input  wire logic sdo   // Data from device
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // One 24-bit frame, MSB first; 600 ns half period beats the sync
  task automatic xfer(input logic r, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {r, a, d};
    q = 8'h00;
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= f[i];
      repeat (6) @(posedge mclk);
      sclk <= 1'b1;
      if (i < 8)
        q[i] = sdo;
      repeat (6) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge mclk);
    cs_n <= 1'b1;
    // Released line must not keep the stale bit
    sdi <= ~f[0];
    repeat (8) @(posedge mclk);
  endtask : xfer
endmodule : rxc_spi_host

// File: test/rxc_ctrl_regs_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module rxc_ctrl_regs_test;
  import rxc_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision code
  logic        mclk, rst_n, sclk, cs_n, sdi, sdo, oe, eoc, slp_r, slp_f;
  logic        lna, mix, ifa, cr, cen, cosc, cst;
  logic [7:0]  rx_set, f_set, f_cfg, res, q, mctl, v [15];
  logic [7:0]  mk [15] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'hFF, 8'h77, 8'h77, 8'h07, 8'hFF, 8'hFE, 8'h7F, 8'h77, 8'h77};
  logic [63:0] rx_sl;
  logic [23:0] f_low, ext;
  logic [11:0] gain;
  logic [3:0]  ch, rx_md, f_md, m;
  logic [2:0]  spl;
  logic [14:0] a;
  logic        sdo_ln;
  int          errors, n_compared, idx;

  rxc_ctrl_regs #(.REV_VALUE(REV)) DUT (.mclk(mclk), .rst_n(rst_n),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(oe), .rx_setup(rx_set), .freq_setup(f_set),
    .rx_sleep(slp_r), .freq_sleep(slp_f), .rx_slots(rx_sl),
    .freq_low_slots(f_low), .ext_mode_cfg(ext), .freq_mode_cfg(f_cfg),
    .conv_eoc(eoc), .conv_result(res), .rx_channel_on(ch),
    .rx_splitter_on(spl), .rx_channel_gain(gain),
    .rx_low_noise_amp_on(lna), .rx_mixer_on(mix),
    .rx_if_amplifier_on(ifa), .mult_control(mctl),
    .receiver_active_mode(rx_md), .freq_active_mode(f_md),
    .converter_clock_rate_select(cr), .converter_enable(cen),
    .converter_osc_on(cosc), .conversion_start_pulse(cst));
  // Released data line shows the inverse of its last bit
  assign sdo_ln = oe ? sdo : ~sdo;
  rxc_spi_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo_ln));

  task automatic wr(input logic [14:0] ad, input logic [7:0] d);
    host.xfer(1'b0, ad, d, q);
  endtask : wr
  task automatic rd(input logic [14:0] ad, input logic [7:0] e);
    host.xfer(1'b1, ad, 8'h00, q);
    `CHK(q, e)
  endtask : rd
  // Expected slot mode: odd states in the upper nibble
  function automatic logic [3:0] fm(input int i);
    logic [63:0] s;
    s = {v[4], v[3], v[2], v[1], v[0], f_low};
    return s[8 * (i / 2) + 4 * (1 - i % 2) +: 4];
  endfunction : fm
  task automatic wrap_up;
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard, counted as a mismatch
  initial begin
    #8000000;
    errors++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    {eoc, slp_r, slp_f} = '0;
    {rx_set, f_set, f_cfg, res} = '0;
    {rx_sl, f_low, ext} = '0;
    void'($urandom(20));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // Reset values, revision, unmapped holes at the end
    for (int i = 0; i < 21; i++) begin
      a = (i < 16) ? 15'h0025 + 15'(i) : 15'h0030 + 15'(i);
      rd(a, (a == 15'h0034) ? REV : 8'h00);
    end
    // Random fill, then readback with reserved bits as zero
    for (int i = 0; i < 15; i++) begin
      v[i] = 8'($urandom);
      wr((i < 12) ? 15'h0025 + 15'(i) : 15'h0034 + 15'(i), v[i]);
    end
    for (int i = 0; i < 15; i++) begin
      a = (i < 12) ? 15'h0025 + 15'(i) : 15'h0034 + 15'(i);
      rd(a, v[i] & mk[i]);
    end
    `CHK(oe, 1'b0)
    `CHK({lna, mix, ifa}, v[6][7:5])
    `CHK(ch, v[6][3:0])
    `CHK(gain, {v[7][6:4], v[7][2:0], v[8][6:4], v[8][2:0]})
    `CHK(spl, v[9][2:0])
    `CHK(mctl, v[10])
    `CHK({cr, cen, cosc}, v[11][7:5])
    // Start pulse, then end of conversion with a fresh word
    res <= 8'($urandom);
    wr(15'h0030, 8'h70);
    `CHK(cst, 1'b1)
    wr(15'h0030, 8'h60);
    `CHK(cst, 1'b0)
    eoc <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(15'h0031, res);
    rd(15'h0030, 8'h61);
    eoc <= 1'b0;
    // Frequency walk over ten states, past the wrap
    f_set <= 8'h9A;
    f_cfg <= 8'($urandom);
    f_low <= 24'($urandom);
    slp_r <= 1'($urandom);
    wr(15'h002A, 8'h08);
    idx = 0;
    for (int k = 0; k < 11; k++) begin
      `CHK(f_md, fm(idx))
      `CHK(mctl, f_cfg)
      rd(15'h0033, {4'(idx), fm(idx)});
      wr(15'h002A, 8'h04);
      idx = (idx == 9) ? 0 : idx + 1;
    end
    // Receiver: mode 0 from own registers, others external
    m = 4'($urandom_range(15, 1));
    rx_set <= 8'h92;
    rx_sl <= {24'($urandom), $urandom, 4'h0, m};
    ext <= 24'($urandom);
    slp_f <= 1'($urandom);
    wr(15'h002A, 8'h02);
    rd(15'h0032, 8'h00);
    `CHK(ch, v[12][3:0])
    `CHK(spl, v[12][6:4])
    `CHK(gain, {v[13][6:4], v[13][2:0], v[14][6:4], v[14][2:0]})
    wr(15'h002A, 8'h01);
    rd(15'h0032, {4'h1, m});
    `CHK(rx_md, m)
    `CHK(ch, ext[19:16])
    wr(15'h002A, 8'h01);
    rd(15'h0032, 8'h00);
    // Latch on: mode 0 edit waits for a step; frozen step keeps count
    rx_set <= 8'hA2;
    slp_f  <= 1'b1;
    wr(15'h0040, ~v[12]);
    `CHK(ch, v[12][3:0])
    wr(15'h002A, 8'h01);
    rd(15'h0032, 8'h00);
    `CHK(ch, ~v[12][3:0])
    wrap_up();
  end
endmodule : rxc_ctrl_regs_test
